/* design/plq_mdio_slave.sv */
/*
  Serial management slave: frames on the clock/data pin pair and turns
  them into one-cycle read and write requests for the register bank.
  Assumes the management clock is at most a quarter of core_clk; both pins
  are sampled through two flip-flops.
*/
`default_nettype none
module plq_mdio_slave
  import plq_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic mdcIn,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic [4:0] phyAddr,
  output plq_mgmt_t req,
  input wire logic [15:0] rdData
);
  logic mdcS1_q, mdcS2_q, mdcS3_q, mdioS1_q, mdioS2_q;
  plq_mdio_state_t st_q, st_d;
  logic [5:0] ones_q, ones_d;
  logic armed_q, armed_d, mine_q, mine_d, isRd_q, isRd_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic out_q, out_d, oe_q, oe_d;
  plq_mgmt_t req_q, req_d;
  logic rise;
  logic [11:0] hdr;

  assign rise = mdcS2_q & ~mdcS3_q;
  assign hdr = {sh_q[10:0], mdioS2_q};

  always_comb begin
    st_d = st_q;
    ones_d = ones_q;
    armed_d = armed_q;
    mine_d = mine_q;
    isRd_d = isRd_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    out_d = out_q;
    oe_d = oe_q;
    req_d = req_q;
    req_d.rd = 1'b0;
    req_d.wr = 1'b0;
    // Read data is presented by the bank in the same cycle as the request
    if (req_q.rd) begin
      sh_d = rdData;
    end
    if (rise) begin
      case (st_q)
        MD_IDLE: begin
          if (mdioS2_q) begin
            if (armed_q) begin
              st_d = MD_HDR;
              cnt_d = 5'h00;
            end
            if (ones_q != PREAMBLE_MIN) begin
              ones_d = ones_q + 6'h01;
            end
            armed_d = 1'b0;
          end else begin
            armed_d = (ones_q == PREAMBLE_MIN);
            ones_d = 6'h00;
          end
        end
        MD_HDR: begin
          sh_d = {sh_q[14:0], mdioS2_q};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'h0B) begin
            mine_d = (hdr[9:5] == phyAddr) &&
              (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE);
            isRd_d = (hdr[11:10] == OP_READ);
            req_d.addr = hdr[4:0];
            req_d.rd = mine_d && isRd_d;
            st_d = MD_TA;
            cnt_d = 5'h00;
          end
        end
        MD_TA: begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'h00) begin
            oe_d = mine_q & isRd_q;
            out_d = 1'b0;
          end else begin
            st_d = MD_DATA;
            cnt_d = 5'h00;
            out_d = sh_q[15];
            if (isRd_q) begin
              sh_d = {sh_q[14:0], 1'b0};
            end
          end
        end
        default: begin
          cnt_d = cnt_q + 5'h01;
          if (isRd_q) begin
            out_d = sh_q[15];
            sh_d = {sh_q[14:0], 1'b0};
          end else begin
            sh_d = {sh_q[14:0], mdioS2_q};
          end
          if (cnt_q == 5'h0F) begin
            oe_d = 1'b0;
            req_d.wr = mine_q & ~isRd_q;
            req_d.data = {sh_q[14:0], mdioS2_q};
            st_d = MD_IDLE;
            ones_d = 6'h00;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mdcS1_q <= 1'b0;
      mdcS2_q <= 1'b0;
      mdcS3_q <= 1'b0;
      mdioS1_q <= 1'b1;
      mdioS2_q <= 1'b1;
      st_q <= MD_IDLE;
      ones_q <= 6'h00;
      armed_q <= 1'b0;
      mine_q <= 1'b0;
      isRd_q <= 1'b0;
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      req_q <= '0;
    end else begin
      mdcS1_q <= mdcIn;
      mdcS2_q <= mdcS1_q;
      mdcS3_q <= mdcS2_q;
      mdioS1_q <= mdioIn;
      mdioS2_q <= mdioS1_q;
      st_q <= st_d;
      ones_q <= ones_d;
      armed_q <= armed_d;
      mine_q <= mine_d;
      isRd_q <= isRd_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      out_q <= out_d;
      oe_q <= oe_d;
      req_q <= req_d;
    end
  end

  assign mdioOut = out_q;
  assign mdioOe = oe_q;
  assign req = req_q;
endmodule
`default_nettype wire

/* design/plq_pkg.sv */
/*
  Package for the port management register bank: register addresses, field
  positions, reset values, timing counts and the carrier structs.
  Assumes a 10 MHz core clock; the serial management frame format is the
  usual clause-22 layout.
*/
`default_nettype none
package plq_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [4:0] ADDR_BMC = 5'h00;
  localparam logic [4:0] ADDR_LQM = 5'h1D;
  localparam logic [4:0] ADDR_LQD = 5'h1E;
  localparam logic [4:0] ADDR_RSVD = 5'h1F;
  // Basic mode control fields
  localparam int BMC_RESET = 15;
  localparam int BMC_LOOP = 14;
  localparam int BMC_SPEED = 13;
  localparam int BMC_ANEG = 12;
  localparam int BMC_PDOWN = 11;
  localparam int BMC_ISO = 10;
  localparam int BMC_RESTART = 9;
  localparam int BMC_DUPLEX = 8;
  localparam logic [7:0] BMC_FIXED_LOW = 8'h00;
  // Link quality fields
  localparam int QUALITY_MONITOR_ENABLE = 15;
  localparam int LQD_BOUND = 8;
  localparam int LQD_SEL_LSB = 9;
  localparam int LQD_THR_WR = 12;
  localparam int LQD_SAMPLE = 13;
  localparam int METRIC_COUNT = 5;
  localparam int THR_COUNT = 10;
  localparam logic [7:0] THR_LOW_RESET = 8'h00;
  localparam logic [7:0] THR_HIGH_RESET = 8'hFF;
  // Timing and management frame opcodes
  localparam int SOFT_RESET_NS = 1000;
  localparam int SOFT_RESET_CYC =
    (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOOP_DEAD_US = 500;
  localparam int LOOP_DEAD_CYC = LOOP_DEAD_US * 1000 / CLK_PERIOD_NS;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [5:0] PREAMBLE_MIN = 6'h20;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] data;
  } plq_mgmt_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [3:0] data;
  } plq_nibble_t;

  typedef struct packed {
    logic speed100;
    logic autoneg;
    logic fullDuplex;
    logic [4:0] phyAddr;
  } plq_strap_t;

  typedef enum logic [2:0] {
    MD_IDLE, MD_HDR, MD_TA, MD_DATA
  } plq_mdio_state_t;
endpackage
`default_nettype wire

/* design/plq_port_regs.sv */
/*
  Management register bank of one transceiver port: basic mode control,
  link quality monitor and link quality data, behind the serial management
  pins. Assumes the MAC nibble path, the negotiation result and the DSP
  metric values come from logic on core_clk; straps and management pins
  are asynchronous and are synchronised here.
*/
// Contract
// R1: Writing 1 to control bit 15 runs a soft reset, reads 1, reloads straps.
// R2: Control bit 14 loops transmit nibbles back to receive; resets to 0.
// R3: After loopback is enabled receive stays invalid for 500 us.
// R4: With negotiation off, control bit 13 picks 100 Mb/s; strap sets it.
// R5: Self-clearing bits set on their event and clear when it ends.
// R6: Clear-on-read bits return their value and clear on that read.
// R7: Latched status holds its event level until read, then tracks live.
// R8: Fixed read-only bits always read their default and ignore writes.
// R9: Monitor register: enable at bit 15, ten warning flags in bits 0-9.
// R10: Data register: value, bound, metric select, write and sample strobes.
// R11: Negotiation on ignores manual speed and duplex; off they take effect.
// R12: Address 1Fh and data register bits 14-15 read zero, ignore writes.
`default_nettype none
module plq_port_regs
  import plq_pkg::*;
#(
  parameter int LOOP_DEAD_CYCLES = LOOP_DEAD_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic mdcIn,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire plq_strap_t strapIn,
  input wire logic anSpeed100,
  input wire logic anFullDuplex,
  input wire plq_nibble_t txFromMac,
  input wire plq_nibble_t rxFromLine,
  output plq_nibble_t rxToMac,
  input wire logic [39:0] metrics,
  output logic speed100,
  output logic fullDuplex,
  output logic autonegEn,
  output logic restartAn,
  output logic loopbackEn,
  output logic powerDown,
  output logic isolate,
  output logic softResetBusy
);
  function automatic logic [7:0] metricOf(logic [39:0] v, logic [2:0] s);
    return v[8*s +: 8];
  endfunction

  function automatic logic [3:0] thrIdx(logic [2:0] s, logic b);
    return {s, b};
  endfunction

  plq_strap_t strapS1_q, strapS2_q;
  plq_mgmt_t req;
  logic [15:0] rdData;
  logic [1:0] initCnt_q, initCnt_d;
  logic srst_q, srst_d, loop_q, loop_d, speed_q, speed_d;
  logic aneg_q, aneg_d, pdown_q, pdown_d, iso_q, iso_d;
  logic restart_q, restart_d, duplex_q, duplex_d;
  logic [7:0] srstCnt_q, srstCnt_d;
  logic [12:0] dead_q, dead_d;
  logic lqmEn_q, lqmEn_d;
  logic [9:0] warn_q, warn_d, warnLive;
  logic [7:0] lqdVal_q, lqdVal_d;
  logic lqdBound_q, lqdBound_d;
  logic [2:0] lqdSel_q, lqdSel_d;
  logic [7:0] thr_q [THR_COUNT];
  logic [7:0] thr_d [THR_COUNT];
  logic effSpeed_q, effDuplex_q;
  plq_nibble_t rx_q, rx_d;
  logic wrBmc, wrLqm, wrLqd, rdLqm, rdLqd, loadStraps;

  plq_mdio_slave u_mdio (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .mdcIn(mdcIn),
    .mdioIn(mdioIn),
    .mdioOut(mdioOut),
    .mdioOe(mdioOe),
    .phyAddr(strapS2_q.phyAddr),
    .req(req),
    .rdData(rdData)
  );

  assign wrBmc = req.wr && req.addr == ADDR_BMC;
  assign wrLqm = req.wr && req.addr == ADDR_LQM;
  assign wrLqd = req.wr && req.addr == ADDR_LQD;
  assign rdLqm = req.rd && req.addr == ADDR_LQM;
  assign rdLqd = req.rd && req.addr == ADDR_LQD;

  // Read mux; unlisted addresses, including the reserved one, read zero
  always_comb begin
    rdData = 16'h0000;
    if (req.addr == ADDR_BMC) begin
      rdData = {srst_q, loop_q, speed_q, aneg_q, pdown_q, iso_q,
        restart_q, duplex_q, BMC_FIXED_LOW}; // R8
    end else if (req.addr == ADDR_LQM) begin
      rdData = {lqmEn_q, 5'h00, warn_q}; // R9
    end else if (req.addr == ADDR_LQD) begin
      rdData = {2'b00, 2'b00, lqdSel_q, lqdBound_q, lqdVal_q}; // R10 R12
    end
  end

  // Monitor compares each metric against its low and high thresholds
  always_comb begin
    for (int k = 0; k < METRIC_COUNT; k++) begin
      warnLive[2*k] = lqmEn_q &&
        metricOf(metrics, 3'(k)) < thr_q[thrIdx(3'(k), 1'b0)];
      warnLive[2*k+1] = lqmEn_q &&
        metricOf(metrics, 3'(k)) > thr_q[thrIdx(3'(k), 1'b1)];
    end
  end

  assign loadStraps = initCnt_q == 2'h1 ||
    (srst_q && srstCnt_q == 8'h01);

  always_comb begin
    initCnt_d = initCnt_q;
    if (initCnt_q != 2'h0) begin
      initCnt_d = initCnt_q - 2'h1;
    end
    srst_d = srst_q;
    srstCnt_d = srstCnt_q;
    loop_d = loop_q;
    speed_d = speed_q;
    aneg_d = aneg_q;
    pdown_d = pdown_q;
    iso_d = iso_q;
    duplex_d = duplex_q;
    restart_d = 1'b0; // R5
    if (srst_q) begin
      srstCnt_d = srstCnt_q - 8'h01;
      if (srstCnt_q == 8'h01) begin
        srst_d = 1'b0; // R1 R5
      end
    end else if (wrBmc) begin
      if (req.data[BMC_RESET]) begin
        srst_d = 1'b1; // R1
        srstCnt_d = 8'(SOFT_RESET_CYC);
      end
      loop_d = req.data[BMC_LOOP]; // R2
      speed_d = req.data[BMC_SPEED]; // R4
      aneg_d = req.data[BMC_ANEG];
      pdown_d = req.data[BMC_PDOWN];
      iso_d = req.data[BMC_ISO];
      duplex_d = req.data[BMC_DUPLEX];
      restart_d = req.data[BMC_RESTART] & aneg_q;
    end
    if (loadStraps) begin
      loop_d = 1'b0; // R1
      speed_d = strapS2_q.speed100; // R4
      aneg_d = strapS2_q.autoneg;
      duplex_d = strapS2_q.fullDuplex;
      pdown_d = 1'b0;
      iso_d = 1'b0;
    end
  end

  // Loopback dead time: receive marked invalid while the counter runs
  always_comb begin
    dead_d = dead_q;
    if (loop_d && !loop_q) begin
      dead_d = 13'(LOOP_DEAD_CYCLES); // R3
    end else if (dead_q != 13'h0000) begin
      dead_d = dead_q - 13'h0001;
    end
    rx_d = rxFromLine;
    if (loop_q) begin
      rx_d = txFromMac; // R2
      if (dead_q != 13'h0000) begin
        rx_d.valid = 1'b0; // R3
        rx_d.err = 1'b0;
      end
    end
  end

  always_comb begin
    lqmEn_d = lqmEn_q;
    if (wrLqm) begin
      lqmEn_d = req.data[QUALITY_MONITOR_ENABLE]; // R9
    end
    // An event in the read cycle wins over the clear
    warn_d = warnLive | (rdLqm ? 10'h000 : warn_q); // R7
    lqdVal_d = lqdVal_q;
    lqdBound_d = lqdBound_q;
    lqdSel_d = lqdSel_q;
    thr_d = thr_q;
    if (rdLqd) begin
      lqdVal_d = 8'h00; // R6
    end
    if (wrLqd) begin
      lqdVal_d = req.data[7:0]; // R10
      lqdBound_d = req.data[LQD_BOUND];
      lqdSel_d = req.data[LQD_SEL_LSB +: 3];
      // Selects past the last metric are taken but write no threshold
      if (req.data[LQD_THR_WR] &&
          req.data[LQD_SEL_LSB +: 3] < 3'(METRIC_COUNT)) begin
        thr_d[thrIdx(req.data[LQD_SEL_LSB +: 3], req.data[LQD_BOUND])] =
          req.data[7:0]; // R10 R5
      end
      if (req.data[LQD_SAMPLE]) begin
        lqdVal_d = metricOf(metrics, req.data[LQD_SEL_LSB +: 3]); // R10
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strapS1_q <= '0;
      strapS2_q <= '0;
      initCnt_q <= STRAP_WAIT;
      srst_q <= 1'b0;
      srstCnt_q <= 8'h00;
      loop_q <= 1'b0;
      speed_q <= 1'b0;
      aneg_q <= 1'b0;
      pdown_q <= 1'b0;
      iso_q <= 1'b0;
      restart_q <= 1'b0;
      duplex_q <= 1'b0;
      dead_q <= 13'h0000;
      rx_q <= '0;
      effSpeed_q <= 1'b0;
      effDuplex_q <= 1'b0;
      lqmEn_q <= 1'b0;
      warn_q <= 10'h000;
      lqdVal_q <= 8'h00;
      lqdBound_q <= 1'b0;
      lqdSel_q <= 3'h0;
      for (int i = 0; i < THR_COUNT; i++) begin
        thr_q[i] <= i[0] ? THR_HIGH_RESET : THR_LOW_RESET;
      end
    end else begin
      strapS1_q <= strapIn;
      strapS2_q <= strapS1_q;
      initCnt_q <= initCnt_d;
      srst_q <= srst_d;
      srstCnt_q <= srstCnt_d;
      loop_q <= loop_d;
      speed_q <= speed_d;
      aneg_q <= aneg_d;
      pdown_q <= pdown_d;
      iso_q <= iso_d;
      restart_q <= restart_d;
      duplex_q <= duplex_d;
      dead_q <= dead_d;
      rx_q <= rx_d;
      effSpeed_q <= aneg_q ? anSpeed100 : speed_q; // R11 R4
      effDuplex_q <= aneg_q ? anFullDuplex : duplex_q; // R11
      lqmEn_q <= lqmEn_d;
      warn_q <= warn_d;
      lqdVal_q <= lqdVal_d;
      lqdBound_q <= lqdBound_d;
      lqdSel_q <= lqdSel_d;
      thr_q <= thr_d;
    end
  end

  assign rxToMac = rx_q;
  assign speed100 = effSpeed_q;
  assign fullDuplex = effDuplex_q;
  assign autonegEn = aneg_q;
  assign restartAn = restart_q;
  assign loopbackEn = loop_q;
  assign powerDown = pdown_q;
  assign isolate = iso_q;
  assign softResetBusy = srst_q;
endmodule
`default_nettype wire

/* tb/phy_basic_control_and_link_quality_regs_tb_top.sv */
/*
  Bench for the port register bank: frames via the station model, MAC
  nibbles and metrics. Assumes the checker binds itself to the design.
*/
`default_nettype none
module phy_basic_control_and_link_quality_regs_tb_top
  import plq_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEAD = 20;
  localparam logic [4:0] PHY = 5'h05;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic mdc, mOut, mOe, mdioOut, mdioOe;
  wire mdioW = mdioOe ? mdioOut : (mOe ? mOut : 1'b1);
  plq_strap_t strapIn;
  logic anSpeed100, anFullDuplex, speed100, fullDuplex, autonegEn;
  logic restartAn, loopbackEn, powerDown, isolate, softResetBusy;
  plq_nibble_t txFromMac, rxFromLine, rxToMac;
  logic [39:0] metrics;
  int fails = 0;
  int n_checks = 0;
  int restarts = 0;
  always #50 core_clk = ~core_clk;
  // The restart output is a one-cycle pulse, so it is counted here
  always @(posedge core_clk) begin
    if (restartAn) begin
      restarts <= restarts + 1;
    end
  end
  plq_port_regs #(.LOOP_DEAD_CYCLES(DEAD)) uut (.core_clk, .reset_n,
    .mdcIn(mdc), .mdioIn(mdioW), .mdioOut, .mdioOe, .strapIn, .anSpeed100,
    .anFullDuplex, .txFromMac, .rxFromLine, .rxToMac, .metrics, .speed100,
    .fullDuplex, .autonegEn, .restartAn, .loopbackEn, .powerDown, .isolate,
    .softResetBusy);
  plq_sme_model sme (.core_clk, .mdio(mdioW), .mdc, .mOut, .mOe);
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] x;
    sme.xfer(1'b1, PHY, a, d, x);
    tick(12);
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    sme.xfer(1'b0, PHY, a, 16'h0000, d);
    chk(d, e);
    tick(4);
  endtask
  task automatic t_default;
    logic [15:0] d;
    rc(ADDR_BMC, 16'h2100);
    chk(16'({speed100, fullDuplex}), 16'h0003);
    chk(16'(loopbackEn), 16'h0000);
    chk(16'(rxToMac), 16'h002A);
    // Foreign address: nobody drives, the pull-up reads back
    sme.xfer(1'b0, PHY + 5'h01, ADDR_BMC, 16'h0000, d);
    chk(d, 16'hFFFF);
    tick(4);
    wr(ADDR_RSVD, 16'hFFFF);
    rc(ADDR_RSVD, 16'h0000);
  endtask
  task automatic t_manual;
    wr(ADDR_BMC, 16'h00FF);
    rc(ADDR_BMC, 16'h0000);
    chk(16'({speed100, fullDuplex}), 16'h0000);
    anSpeed100 = 1'b0;
    anFullDuplex = 1'b0;
    wr(ADDR_BMC, 16'h3100);
    chk(16'({speed100, fullDuplex}), 16'h0000);
    anSpeed100 = 1'b1;
    tick(3);
    chk(16'({speed100, fullDuplex}), 16'h0002);
    wr(ADDR_BMC, 16'h1200);
    rc(ADDR_BMC, 16'h1000);
    chk(16'(restarts), 16'h0001);
  endtask
  task automatic t_soft;
    logic [15:0] x;
    int n;
    n = 0;
    wr(ADDR_BMC, 16'h4C00);
    chk(16'({loopbackEn, powerDown, isolate}), 16'h0007);
    // Setting these bits with the reset shows the reload clears them
    sme.xfer(1'b1, PHY, ADDR_BMC, 16'hCC00, x);
    for (int i = 0; i < 30 && !softResetBusy; i++) tick(1);
    chk(16'(softResetBusy), 16'h0001);
    for (int i = 0; i < 30 && softResetBusy; i++) begin
      n++;
      tick(1);
    end
    chk(16'(n), 16'(SOFT_RESET_CYC));
    tick(4);
    rc(ADDR_BMC, 16'h2100);
    chk(16'({loopbackEn, powerDown, isolate}), 16'h0000);
  endtask
  task automatic t_loop;
    logic [15:0] x;
    plq_nibble_t p;
    txFromMac = 6'h30;
    sme.xfer(1'b1, PHY, ADDR_BMC, 16'h6100, x);
    for (int i = 0; i < 20 && !loopbackEn; i++) tick(1);
    chk(16'(loopbackEn), 16'h0001);
    for (int i = 0; i < DEAD - 3; i++) begin
      txFromMac.data = txFromMac.data + 4'h1;
      tick(1);
      chk(16'(rxToMac.valid), 16'h0000);
    end
    tick(8);
    for (int i = 0; i < 8; i++) begin
      txFromMac.data = txFromMac.data + 4'h1;
      p = txFromMac;
      tick(1);
      chk(16'(rxToMac), 16'(p));
    end
    wr(ADDR_BMC, 16'h2100);
    chk(16'(rxToMac), 16'h002A);
  endtask
  task automatic t_quality;
    logic [15:0] f;
    wr(ADDR_LQM, 16'h83FF);
    rc(ADDR_LQM, 16'h8000);
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < METRIC_COUNT; k++) begin
        f = 16'h8000 | (16'h0001 << (2 * k + b));
        wr(ADDR_LQD, {4'h1, 3'(k), 1'(b), b ? 8'h70 : 8'h90});
        rc(ADDR_LQM, f);
        wr(ADDR_LQD, {4'h1, 3'(k), 1'(b), b ? 8'hFF : 8'h00});
        rc(ADDR_LQM, f);
      end
    end
    rc(ADDR_LQM, 16'h8000);
    metrics[39:32] = 8'hC3;
    wr(ADDR_LQD, 16'hE800);
    rc(ADDR_LQD, 16'h08C3);
    rc(ADDR_LQD, 16'h0800);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    strapIn = {3'b101, PHY};
    anSpeed100 = 1'b1;
    anFullDuplex = 1'b1;
    txFromMac = '0;
    rxFromLine = 6'h2A;
    metrics = {5{8'h80}};
    repeat (10) @(posedge core_clk);
    #1 reset_n = 1'b1;
    tick(6);
    t_default;
    t_manual;
    t_soft;
    t_loop;
    t_quality;
    test_done;
  end
endmodule
`default_nettype wire

/* tb/plq_port_regs_checker.sv */
/*
  Checker for the port register bank, bound to its top module.
  Assumes every port it watches except strapIn is on core_clk with reset_n as reset.
*/
`default_nettype none
module plq_port_regs_checker
  import plq_pkg::*;
#(
  parameter int LOOP_DEAD_CYCLES = LOOP_DEAD_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire plq_strap_t strapIn,
  input wire logic anSpeed100,
  input wire logic anFullDuplex,
  input wire plq_nibble_t txFromMac,
  input wire plq_nibble_t rxFromLine,
  input wire plq_nibble_t rxToMac,
  input wire logic speed100,
  input wire logic fullDuplex,
  input wire logic autonegEn,
  input wire logic restartAn,
  input wire logic loopbackEn,
  input wire logic powerDown,
  input wire logic isolate,
  input wire logic softResetBusy
);
  timeunit 1ns;
  timeprecision 1ns;
  int busyCnt_q, busyCnt_d, loopCnt_q, loopCnt_d;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Saturates so a long loopback session cannot wrap the count
  always_comb begin
    busyCnt_d = softResetBusy ? busyCnt_q + 1 : 0;
    loopCnt_d = 0;
    if (loopbackEn) begin
      loopCnt_d = loopCnt_q + (loopCnt_q < LOOP_DEAD_CYCLES + 8 ? 1 : 0);
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busyCnt_q <= 0;
      loopCnt_q <= 0;
    end else begin
      busyCnt_q <= busyCnt_d;
      loopCnt_q <= loopCnt_d;
    end
  end
  sequence s_an_held;
    autonegEn ##1 autonegEn;
  endsequence
  sequence s_pulse_end;
    autonegEn ##1 !restartAn;
  endsequence
  AST_BUSY_LEN: assert property (
    $fell(softResetBusy) |-> busyCnt_q == SOFT_RESET_CYC)
    else $error("soft reset length wrong");
  AST_BUSY_HOLD: assert property (
    softResetBusy && $past(softResetBusy) |->
    $stable(autonegEn) && $stable(loopbackEn))
    else $error("control changed during soft reset");
  AST_RESTRAP: assert property (
    $fell(softResetBusy) |-> ##3 autonegEn == strapIn.autoneg && !loopbackEn)
    else $error("straps not reloaded");
  AST_LOOP_DEAD: assert property (
    loopbackEn && loopCnt_q inside {[2:LOOP_DEAD_CYCLES - 3]} |->
    !rxToMac.valid && !rxToMac.err)
    else $error("receive valid during dead time");
  AST_LOOP_PATH: assert property (
    loopbackEn && loopCnt_q > LOOP_DEAD_CYCLES + 2 |->
    rxToMac == $past(txFromMac))
    else $error("loopback data wrong");
  AST_LINE_PATH: assert property (
    $past(reset_n) && !loopbackEn && !$past(loopbackEn) && !isolate &&
    !powerDown && !softResetBusy && !$past(softResetBusy) |->
    rxToMac == $past(rxFromLine))
    else $error("line data wrong");
  AST_AN_SPEED: assert property (
    s_an_held |-> speed100 == $past(anSpeed100))
    else $error("negotiated speed not used");
  AST_AN_DUPLEX: assert property (
    s_an_held |-> fullDuplex == $past(anFullDuplex))
    else $error("negotiated duplex not used");
  AST_RESTART_PULSE: assert property (
    restartAn |-> s_pulse_end)
    else $error("restart not a single pulse");
endmodule
bind plq_port_regs plq_port_regs_checker #(
  .LOOP_DEAD_CYCLES(LOOP_DEAD_CYCLES)
) chk (.core_clk, .reset_n, .strapIn, .anSpeed100, .anFullDuplex,
  .txFromMac, .rxFromLine, .rxToMac, .speed100, .fullDuplex, .autonegEn,
  .restartAn, .loopbackEn, .powerDown, .isolate, .softResetBusy);
`default_nettype wire

/* tb/plq_sme_model.sv */
/*
  Management station model: sends clause-22 frames on the pin pair.
  Assumes the bench resolves the data wire with a pull-up.
*/
`default_nettype none
module plq_sme_model
  import plq_pkg::*;
(
  input wire logic core_clk,
  input wire logic mdio,
  output logic mdc,
  output logic mOut,
  output logic mOe
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock stands low between frames
  initial begin
    mdc = 1'b0;
    mOut = 1'b1;
    mOe = 1'b0;
  end
  // Eight core cycles a bit keeps below a quarter of core_clk
  task automatic step(input logic v, input logic oe, output logic s);
    mOut = v;
    mOe = oe;
    repeat (4) @(posedge core_clk);
    s = mdio;
    #1 mdc = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 mdc = 1'b0;
  endtask
  task automatic xfer(input logic wr, input logic [4:0] pa, ra,
      input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] hdr;
    logic s;
    hdr = {2'b01, wr ? OP_WRITE : OP_READ, pa, ra, 2'b10, wd};
    rd = '0;
    for (int i = 0; i < 32; i++) step(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      step(hdr[i], wr || i > 17, s);
      if (i < 16) rd = {rd[14:0], s};
    end
    mOe = 1'b0;
  endtask
endmodule
`default_nettype wire
